/* logic/capu_defs.vh */
// Constants for the compare and PWM unit: register offsets, field positions, reset values and codes.
// Assumes a plain byte-wide register port with a 4-bit address.
`ifndef CAPU_DEFS_VH
`define CAPU_DEFS_VH

// ==========================================================================
// Register offsets
`define CAPU_OFS_U1_LOW 4'h0
`define CAPU_OFS_U1_HIGH 4'h1
`define CAPU_OFS_U1_CTRL 4'h2
`define CAPU_OFS_U2_LOW 4'h3
`define CAPU_OFS_U2_HIGH 4'h4
`define CAPU_OFS_U2_CTRL 4'h5
`define CAPU_OFS_BASE_COUNT 4'h6
`define CAPU_OFS_PERIOD 4'h7
`define CAPU_OFS_BASE_CTRL 4'h8
`define CAPU_OFS_TIMER_SEL 4'h9
`define CAPU_OFS_STATUS 4'ha

// ==========================================================================
// Field positions
`define CAPU_CTRL_DUTY_HI 5
`define CAPU_CTRL_DUTY_LO 4
`define CAPU_CTRL_FUNC_HI 3
`define CAPU_CTRL_FUNC_LO 0
`define CAPU_BASE_PRE_HI 1
`define CAPU_BASE_PRE_LO 0
`define CAPU_BASE_ENABLE 2
`define CAPU_BASE_POST_HI 6
`define CAPU_BASE_POST_LO 3
`define CAPU_STAT_U1_FLAG 0
`define CAPU_STAT_U2_FLAG 1
`define CAPU_STAT_BASE_FLAG 2

// ==========================================================================
// Reset values
`define CAPU_RST_CTRL 8'h00
`define CAPU_RST_BASE_COUNT 8'h00
`define CAPU_RST_PERIOD 8'hff
`define CAPU_RST_BASE_CTRL 8'h00
`define CAPU_RST_TIMER_SEL 8'h00

// ==========================================================================
// Function select codes
`define CAPU_FN_OFF 4'h0
`define CAPU_FN_TOGGLE 4'h2
`define CAPU_FN_FORCE_HIGH 4'h8
`define CAPU_FN_FORCE_LOW 4'h9
`define CAPU_FN_SOFT 4'ha
`define CAPU_FN_SPECIAL 4'hb
`define CAPU_FN_PWM_TOP 2'h3

// ==========================================================================
// Base timer prescale codes and phase widths
`define CAPU_PRE_DIV1 2'h0
`define CAPU_PRE_DIV4 2'h1
`define CAPU_PHASE_MAX_DIV1 6'h03
`define CAPU_PHASE_MAX_DIV4 6'h0f
`define CAPU_PHASE_MAX_DIV16 6'h3f

`endif

/* logic/capu_top.v */
// Compare and PWM unit: two compare/PWM channels, the PWM base timer and the register port.
// Assumes the two 16-bit timers live outside and take their reset pulses from here,
// and that clk_sys is the quarter-phase clock of the core instruction cycle.
//
// Contract
// - Compare value checked against selected 16-bit timer.
// - Match drives pin high, low, toggles or leaves.
// - Match flag set with the pin action.
// - Control zero forces output latch low.
// - Software-event code only raises match event.
// - First unit trigger resets its timer.
// - Trigger resets the unit's selected timer.
// - Second unit trigger starts enabled conversion.
// - Trigger reset never sets timer overflow flags.
// - PWM output with 10-bit duty resolution.
// - Period comes from period register.
// - Period match clears timer, sets pin, loads; pin stays low when the new duty is zero.
// - Postscaler excluded from PWM period.
// - Duty is low byte plus control bits.
// - Duty moves to shadow only at period.
// - Shadow is read-only in PWM mode.
// - Pin clears when shadow equals extended timer.
// - Duty beyond period never clears pin.
// - Base prescaler divides by 1, 4, 16.
// - Compare function codes and their pin actions.
// - Code zero resets unit; 11xx selects PWM.
`timescale 1ns/1ps
`include "capu_defs.vh"

// ==========================================================================
// One compare/PWM channel
module capu_unit (
	input wire clk_sys,
	input wire rst,
	input wire clk_en,
	input wire [7:0] wdata,
	input wire wr_low,
	input wire wr_high,
	input wire wr_ctrl,
	input wire flag_clr,
	input wire [15:0] count,
	input wire [7:0] base_count,
	input wire [1:0] extra,
	input wire period_roll,
	output reg [7:0] value_low,
	output reg [7:0] value_high,
	output reg [5:0] ctrl,
	output reg pin,
	output reg flag,
	output reg trig
);
	reg [1:0] shadow_low;
	reg eq_q;
	wire [3:0] func;
	wire pwm_mode;
	wire cmp_mode;
	wire eq;
	wire hit;
	wire [9:0] pending_duty;
	wire init_wr;

	assign func = ctrl[`CAPU_CTRL_FUNC_HI:`CAPU_CTRL_FUNC_LO];
	assign pwm_mode = (func[3:2] == `CAPU_FN_PWM_TOP);
	assign cmp_mode = (func == `CAPU_FN_TOGGLE) || (func == `CAPU_FN_FORCE_HIGH) || (func == `CAPU_FN_FORCE_LOW) ||
		(func == `CAPU_FN_SOFT) || (func == `CAPU_FN_SPECIAL);
	assign eq = cmp_mode && ({value_high, value_low} == count);
	// A long stretch of equality (timer stopped) gives one event, not one per cycle.
	assign hit = eq && !eq_q;
	assign pending_duty = {value_low, ctrl[`CAPU_CTRL_DUTY_HI:`CAPU_CTRL_DUTY_LO]};
	assign init_wr = wr_ctrl && ((wdata[3:0] == `CAPU_FN_OFF) || (wdata[3:0] == `CAPU_FN_FORCE_HIGH) ||
		(wdata[3:0] == `CAPU_FN_FORCE_LOW));

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			value_low <= 8'h00;
			value_high <= 8'h00;
			ctrl <= 6'h00;
			shadow_low <= 2'h0;
			eq_q <= 1'b0;
			pin <= 1'b0;
			flag <= 1'b0;
			trig <= 1'b0;
		end else if (clk_en) begin
			eq_q <= eq;
			// Set wins over a clear arriving in the same cycle.
			flag <= hit | (flag & ~flag_clr);
			trig <= hit && (func == `CAPU_FN_SPECIAL);
			if (wr_low) begin
				value_low <= wdata;
			end
			if (wr_high && !pwm_mode) begin
				value_high <= wdata;
			end
			if (wr_ctrl) begin
				ctrl <= wdata[5:0];
				eq_q <= 1'b0;
				trig <= 1'b0;
			end
			// Other control writes fall through, so rewriting the duty bits never swallows a period start.
			if (init_wr) begin
				case (wdata[3:0])
					`CAPU_FN_OFF: begin
						pin <= 1'b0;
					end
					`CAPU_FN_FORCE_HIGH: begin
						pin <= 1'b0;
					end
					`CAPU_FN_FORCE_LOW: begin
						pin <= 1'b1;
					end
					default: begin
						pin <= pin;
					end
				endcase
			end else if (pwm_mode) begin
				if (period_roll) begin
					value_high <= value_low;
					shadow_low <= ctrl[`CAPU_CTRL_DUTY_HI:`CAPU_CTRL_DUTY_LO];
					pin <= (pending_duty != 10'h000);
				end else if ({value_high, shadow_low} == {base_count, extra}) begin
					// A duty beyond the period never meets the timer, so the pin stays high.
					pin <= 1'b0;
				end
			end else if (hit) begin
				case (func)
					`CAPU_FN_TOGGLE: begin
						pin <= ~pin;
					end
					`CAPU_FN_FORCE_HIGH: begin
						pin <= 1'b1;
					end
					`CAPU_FN_FORCE_LOW: begin
						pin <= 1'b0;
					end
					default: begin
						pin <= pin;
					end
				endcase
			end
		end
	end
endmodule // capu_unit

// ==========================================================================
// Top level
module capu_top (
	input wire clk_sys,
	input wire rst,
	input wire clk_en,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [15:0] timer_a_count,
	input wire [15:0] timer_b_count,
	input wire adc_enable,
	output reg first_unit_pin,
	output reg second_unit_pin,
	output reg timer_a_reset,
	output reg timer_b_reset,
	output reg overflow_suppress,
	output reg adc_start,
	output reg base_tick
);
	reg [7:0] pwm_base_count;
	reg [7:0] pwm_period_value;
	reg [7:0] base_timer_control;
	reg [1:0] timer_select;
	reg [5:0] phase;
	reg [3:0] post_count;
	reg base_flag;
	reg [5:0] phase_max;
	reg [1:0] extra;
	reg [5:0] next_phase;
	reg [7:0] next_count;
	wire base_run;
	wire base_inc;
	wire period_roll;
	wire [7:0] u1_low;
	wire [7:0] u1_high;
	wire [5:0] u1_ctrl;
	wire u1_pin;
	wire u1_flag;
	wire u1_trig;
	wire [7:0] u2_low;
	wire [7:0] u2_high;
	wire [5:0] u2_ctrl;
	wire u2_pin;
	wire u2_flag;
	wire u2_trig;
	wire flag_wr;

	assign flag_wr = reg_wr && (reg_addr == `CAPU_OFS_STATUS);

	// ======================================================================
	// Base timer prescaler and extra duty bits
	always @* begin
		case (base_timer_control[`CAPU_BASE_PRE_HI:`CAPU_BASE_PRE_LO])
			`CAPU_PRE_DIV1: begin
				phase_max = `CAPU_PHASE_MAX_DIV1;
			end
			`CAPU_PRE_DIV4: begin
				phase_max = `CAPU_PHASE_MAX_DIV4;
			end
			default: begin
				phase_max = `CAPU_PHASE_MAX_DIV16;
			end
		endcase
		next_phase = phase;
		next_count = pwm_base_count;
		if (base_run && (phase == phase_max)) begin
			next_phase = 6'h00;
			if (pwm_base_count == pwm_period_value) begin
				next_count = 8'h00;
			end else begin
				next_count = pwm_base_count + 8'h01;
			end
		end else if (base_run) begin
			next_phase = phase + 6'h01;
		end
		// Channels see the timer value this edge produces, so the pin falls exactly duty steps after the roll.
		case (base_timer_control[`CAPU_BASE_PRE_HI:`CAPU_BASE_PRE_LO])
			`CAPU_PRE_DIV1: begin
				extra = next_phase[1:0];
			end
			`CAPU_PRE_DIV4: begin
				extra = next_phase[3:2];
			end
			default: begin
				extra = next_phase[5:4];
			end
		endcase
	end

	assign base_run = base_timer_control[`CAPU_BASE_ENABLE];
	assign base_inc = base_run && (phase == phase_max);
	assign period_roll = base_inc && (pwm_base_count == pwm_period_value);

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase <= 6'h00;
			pwm_base_count <= `CAPU_RST_BASE_COUNT;
			pwm_period_value <= `CAPU_RST_PERIOD;
			base_timer_control <= `CAPU_RST_BASE_CTRL;
			timer_select <= 2'h0;
			post_count <= 4'h0;
			base_flag <= 1'b0;
			base_tick <= 1'b0;
		end else if (clk_en) begin
			base_tick <= 1'b0;
			phase <= next_phase;
			pwm_base_count <= next_count;
			// The postscaler only paces the tick and the base flag; the period above never looks at it.
			if (period_roll) begin
				if (post_count == base_timer_control[`CAPU_BASE_POST_HI:`CAPU_BASE_POST_LO]) begin
					post_count <= 4'h0;
					base_tick <= 1'b1;
				end else begin
					post_count <= post_count + 4'h1;
				end
			end
			base_flag <= (period_roll && post_count == base_timer_control[`CAPU_BASE_POST_HI:`CAPU_BASE_POST_LO]) |
				(base_flag & ~(flag_wr & reg_wdata[`CAPU_STAT_BASE_FLAG]));
			if (reg_wr) begin
				case (reg_addr)
					`CAPU_OFS_BASE_COUNT: begin
						pwm_base_count <= reg_wdata;
						phase <= 6'h00;
					end
					`CAPU_OFS_PERIOD: begin
						pwm_period_value <= reg_wdata;
					end
					`CAPU_OFS_BASE_CTRL: begin
						base_timer_control <= {1'b0, reg_wdata[6:0]};
					end
					`CAPU_OFS_TIMER_SEL: begin
						timer_select <= reg_wdata[1:0];
					end
					default: begin
						timer_select <= timer_select;
					end
				endcase
			end
		end
	end

	// ======================================================================
	// Channels
	capu_unit u_first (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_en(clk_en),
		.wdata(reg_wdata),
		.wr_low(reg_wr && reg_addr == `CAPU_OFS_U1_LOW),
		.wr_high(reg_wr && reg_addr == `CAPU_OFS_U1_HIGH),
		.wr_ctrl(reg_wr && reg_addr == `CAPU_OFS_U1_CTRL),
		.flag_clr(flag_wr && reg_wdata[`CAPU_STAT_U1_FLAG]),
		.count(timer_select[0] ? timer_b_count : timer_a_count),
		.base_count(next_count),
		.extra(extra),
		.period_roll(period_roll),
		.value_low(u1_low),
		.value_high(u1_high),
		.ctrl(u1_ctrl),
		.pin(u1_pin),
		.flag(u1_flag),
		.trig(u1_trig)
	);

	capu_unit u_second (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_en(clk_en),
		.wdata(reg_wdata),
		.wr_low(reg_wr && reg_addr == `CAPU_OFS_U2_LOW),
		.wr_high(reg_wr && reg_addr == `CAPU_OFS_U2_HIGH),
		.wr_ctrl(reg_wr && reg_addr == `CAPU_OFS_U2_CTRL),
		.flag_clr(flag_wr && reg_wdata[`CAPU_STAT_U2_FLAG]),
		.count(timer_select[1] ? timer_b_count : timer_a_count),
		.base_count(next_count),
		.extra(extra),
		.period_roll(period_roll),
		.value_low(u2_low),
		.value_high(u2_high),
		.ctrl(u2_ctrl),
		.pin(u2_pin),
		.flag(u2_flag),
		.trig(u2_trig)
	);

	// ======================================================================
	// Pins, trigger routing and read port
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			first_unit_pin <= 1'b0;
			second_unit_pin <= 1'b0;
			timer_a_reset <= 1'b0;
			timer_b_reset <= 1'b0;
			overflow_suppress <= 1'b0;
			adc_start <= 1'b0;
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			first_unit_pin <= u1_pin;
			second_unit_pin <= u2_pin;
			timer_a_reset <= (u1_trig && !timer_select[0]) || (u2_trig && !timer_select[1]);
			timer_b_reset <= (u1_trig && timer_select[0]) || (u2_trig && timer_select[1]);
			// The timers treat this as a clear, not a wrap, so no overflow flag follows.
			overflow_suppress <= u1_trig || u2_trig;
			adc_start <= u2_trig && adc_enable;
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`CAPU_OFS_U1_LOW: reg_rdata <= u1_low;
					`CAPU_OFS_U1_HIGH: reg_rdata <= u1_high;
					`CAPU_OFS_U1_CTRL: reg_rdata <= {2'b00, u1_ctrl};
					`CAPU_OFS_U2_LOW: reg_rdata <= u2_low;
					`CAPU_OFS_U2_HIGH: reg_rdata <= u2_high;
					`CAPU_OFS_U2_CTRL: reg_rdata <= {2'b00, u2_ctrl};
					`CAPU_OFS_BASE_COUNT: reg_rdata <= pwm_base_count;
					`CAPU_OFS_PERIOD: reg_rdata <= pwm_period_value;
					`CAPU_OFS_BASE_CTRL: reg_rdata <= base_timer_control;
					`CAPU_OFS_TIMER_SEL: reg_rdata <= {6'h00, timer_select};
					`CAPU_OFS_STATUS: reg_rdata <= {5'h00, base_flag, u2_flag, u1_flag};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // capu_top

/* dv/capu_chk.sv */
// Concurrent checks on the ports of the compare and PWM unit top level.
// Assumes clk_en stays high and the timers sit outside the unit.
`timescale 1ns/1ps
`include "capu_defs.vh"

// ==========
// Checker
module capu_chk (
	input wire clk_sys,
	input wire rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire adc_enable,
	input wire first_unit_pin,
	input wire timer_a_reset,
	input wire timer_b_reset,
	input wire overflow_suppress,
	input wire adc_start
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire ctl_wr = reg_wr && reg_addr == `CAPU_OFS_U1_CTRL;
	property p_sup_a; timer_a_reset |-> overflow_suppress; endproperty
	property p_sup_b; timer_b_reset |-> overflow_suppress; endproperty
	property p_sup_src; overflow_suppress |-> timer_a_reset || timer_b_reset; endproperty
	property p_adc; adc_start |-> overflow_suppress && $past(adc_enable); endproperty
	property p_once; timer_a_reset |=> !timer_a_reset; endproperty
	property p_off; ctl_wr && reg_wdata == 8'h00 |-> ##2 !first_unit_pin; endproperty
	property p_init_hi; ctl_wr && reg_wdata[3:0] == `CAPU_FN_FORCE_LOW |-> ##2 first_unit_pin; endproperty
	property p_init_lo; ctl_wr && reg_wdata[3:0] == `CAPU_FN_FORCE_HIGH |-> ##2 !first_unit_pin; endproperty
	a_sup_a: assert property (p_sup_a) else $error("timer A reset without flag suppress");
	a_sup_b: assert property (p_sup_b) else $error("timer B reset without flag suppress");
	a_sup_src: assert property (p_sup_src) else $error("suppress without a timer reset");
	a_adc: assert property (p_adc) else $error("bad conversion start");
	a_once: assert property (p_once) else $error("trigger longer than one cycle");
	a_off: assert property (p_off) else $error("pin not low after unit off");
	a_init_hi: assert property (p_init_hi) else $error("pin not started high");
	a_init_lo: assert property (p_init_lo) else $error("pin not started low");
	c_trig: cover property (timer_a_reset);
	c_adc: cover property (adc_start);
	c_pin: cover property ($rose(first_unit_pin));
endmodule // capu_chk

bind capu_top capu_chk capu_chk_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .adc_enable(adc_enable), .first_unit_pin(first_unit_pin),
	.timer_a_reset(timer_a_reset), .timer_b_reset(timer_b_reset), .overflow_suppress(overflow_suppress),
	.adc_start(adc_start));

/* dv/capu_timers.sv */
// Model of the two 16-bit timers that the unit compares against and resets.
// Assumes run and clear are levels from the bench.
`timescale 1ns/1ps

// ==========
// Timers
module capu_timers (
	input wire clk_sys,
	input wire rst,
	input wire run,
	input wire clear,
	input wire timer_a_reset,
	input wire timer_b_reset,
	output logic [15:0] timer_a_count,
	output logic [15:0] timer_b_count
);
	// Both count on clk_sys itself, since a free-running asynchronous count could skip the match.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_a_count <= 16'h0000;
			timer_b_count <= 16'h0000;
		end else begin
			timer_a_count <= (clear || timer_a_reset) ? 16'h0000 : timer_a_count + {15'h0000, run};
			timer_b_count <= (clear || timer_b_reset) ? 16'h0000 : timer_b_count + {15'h0000, run};
		end
	end
endmodule // capu_timers

/* dv/tb_top.sv */
// Self-checking bench for the compare and PWM unit.
// Assumes the register map of the defines header and a 125 MHz clk_sys.
`timescale 1ns/1ps
`include "capu_defs.vh"

// ==========
// Bench
module tb_top;
	logic clk_sys, rst, clk_en, reg_wr, reg_rd, adc_enable, run, clear;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, rd_data;
	wire [7:0] reg_rdata;
	wire [15:0] timer_a_count, timer_b_count;
	wire first_unit_pin, second_unit_pin, timer_a_reset, timer_b_reset, adc_start, base_tick;
	int num_errors, tests_run, n, hi, adc_n, tk;
	logic [3:0] fn [5] = '{`CAPU_FN_FORCE_HIGH, `CAPU_FN_FORCE_LOW, `CAPU_FN_TOGGLE, `CAPU_FN_SOFT, `CAPU_FN_SPECIAL};
	logic [1:0] pe [5] = '{2'b01, 2'b10, 2'b01, 2'b00, 2'b00};
	logic [7:0] bc [4] = '{8'h04, 8'h05, 8'h06, 8'h7c};
	int wn [4] = '{64, 256, 1024, 128};
	int tn [4] = '{8, 8, 8, 1};
	logic [7:0] dl [3] = '{8'h00, 8'h01, 8'h03};
	logic [1:0] db [3] = '{2'b00, 2'b10, 2'b00};
	int dh [3] = '{0, 48, 64};

	capu_top capu_top_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_a_count(timer_a_count), .timer_b_count(timer_b_count), .adc_enable(adc_enable),
		.first_unit_pin(first_unit_pin), .second_unit_pin(second_unit_pin), .timer_a_reset(timer_a_reset),
		.timer_b_reset(timer_b_reset), .overflow_suppress(), .adc_start(adc_start), .base_tick(base_tick));
	capu_timers capu_timers_inst (.clk_sys(clk_sys), .rst(rst), .run(run), .clear(clear),
		.timer_a_reset(timer_a_reset), .timer_b_reset(timer_b_reset),
		.timer_a_count(timer_a_count), .timer_b_count(timer_b_count));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task chk_reg(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: pin %b expected %b", $time, got, exp);
		end
	endtask

	task chk_cnt(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			num_errors++;
			$display("ERROR %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask

	task rdc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_data = reg_rdata;
		chk_reg(rd_data, exp);
	endtask

	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task meas(input int k);
		hi = 0;
		tk = 0;
		repeat (k) begin
			@(negedge clk_sys);
			hi += (first_unit_pin === 1'b1) ? 1 : ((first_unit_pin === 1'b0) ? 0 : 1000);
			tk += (base_tick === 1'b1) ? 1 : ((base_tick === 1'b0) ? 0 : 1000);
		end
	endtask

	// Waits for one reset pulse, then counts cycles and conversion starts up to the next one.
	task gap(input logic b);
		n = 0;
		do @(negedge clk_sys); while ((b ? timer_b_reset : timer_a_reset) !== 1'b1 && ++n < 200);
		n = 0;
		adc_n = 0;
		do begin
			@(negedge clk_sys);
			n++;
			adc_n += adc_start;
		end while ((b ? timer_b_reset : timer_a_reset) !== 1'b1 && n < 200);
	endtask

	task results;
		$display("Errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#200000;
		num_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		results;
	end

	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, adc_enable, reg_addr, reg_wdata} = '0;
		clk_en = 1'b1;
		run = 1'b1;
		clear = 1'b1;
		cyc(2);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++) rdc(i[3:0], (i == 7) ? `CAPU_RST_PERIOD : 8'h00);
		wr(4'h5, 8'hf2);
		rdc(4'h5, 8'h32);
		chk_bit(second_unit_pin, 1'b1);
		wr(4'h5, 8'h00);
		wr(4'hb, 8'h5a);
		rdc(4'hb, 8'h00);
		chk_bit(second_unit_pin, 1'b0);
		wr(4'ha, 8'h03);
		wr(4'h0, 8'h10);
		for (int i = 0; i < 5; i++) begin
			clear <= 1'b1;
			wr(4'h2, 8'h00);
			wr(4'h2, {4'h0, fn[i]});
			cyc(4);
			chk_bit(first_unit_pin, pe[i][1]);
			clear <= 1'b0;
			cyc(12);
			chk_bit(first_unit_pin, pe[i][1]);
			cyc(12);
			chk_bit(first_unit_pin, pe[i][0]);
			rdc(4'ha, 8'h01);
			wr(4'ha, 8'h01);
		end
		clear <= 1'b1;
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h00);
		wr(4'h2, {4'h0, `CAPU_FN_SOFT});
		rdc(4'ha, 8'h01);
		wr(4'ha, 8'h01);
		cyc(8);
		rdc(4'ha, 8'h00);
		wr(4'h0, 8'h0a);
		wr(4'h2, {4'h0, `CAPU_FN_SPECIAL});
		clear <= 1'b0;
		gap(1'b0);
		chk_cnt(n, 13);
		clear <= 1'b1;
		wr(4'h2, 8'h00);
		wr(4'h9, 8'h02);
		wr(4'h3, 8'h07);
		adc_enable <= 1'b1;
		wr(4'h5, {4'h0, `CAPU_FN_SPECIAL});
		clear <= 1'b0;
		gap(1'b1);
		chk_cnt(n, 10);
		chk_cnt(adc_n, 1);
		cyc(1);
		adc_enable <= 1'b0;
		gap(1'b1);
		chk_cnt(adc_n, 0);
		wr(4'h5, 8'h00);
		// Setup follows the safe order so no stray edge appears on the pin.
		wr(4'h7, 8'h01);
		wr(4'h0, 8'h01);
		wr(4'h8, 8'h04);
		wr(4'h2, 8'h0c);
		for (int i = 0; i < 4; i++) begin
			wr(4'h8, bc[i]);
			cyc(wn[i]);
			meas(wn[i]);
			chk_cnt(hi, wn[i] / 2);
			chk_cnt(tk, tn[i]);
		end
		wr(4'h8, 8'h04);
		for (int i = 0; i < 3; i++) begin
			wr(4'h0, dl[i]);
			wr(4'h2, {2'b00, db[i], 4'hc});
			cyc(24);
			meas(64);
			chk_cnt(hi, dh[i]);
		end
		wr(4'h8, 8'h00);
		wr(4'h0, 8'h55);
		rdc(4'h1, 8'h03);
		wr(4'h1, 8'haa);
		rdc(4'h1, 8'h03);
		wr(4'h8, 8'h04);
		cyc(16);
		rdc(4'h1, 8'h55);
		cyc(1);
		clk_en <= 1'b0;
		wr(4'h7, 8'h33);
		clk_en <= 1'b1;
		rdc(4'h7, 8'h01);
		wr(4'h2, 8'h00);
		cyc(2);
		chk_bit(first_unit_pin, 1'b0);
		results;
	end
endmodule // tb_top
